// ===== hw/rtcs_top.sv
// Real-time clock with alarm, event flags, and CPU clock source select.
// Assumes crystal and VCO arrive as pins and are sampled on i_sys_clk.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

module rtcs_top #(
   parameter int LOCK_COUNT = 8
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr_stb,
   input  wire logic       i_rd_stb,
   output logic      [7:0] o_rd_data,
   input  wire logic       i_osc_32k,
   input  wire logic       i_vco_clk,
   input  wire logic       i_stop_mode,
   output logic            o_cpu_clock_source_select,
   output logic            o_osc_enable,
   output logic            o_pump_up,
   output logic            o_pump_dn,
   output logic            o_rtc_irq
);

   if (LOCK_COUNT < 1 || LOCK_COUNT > 15) begin : g_bad_lock
      $error("rtcs_top: LOCK_COUNT must be 1 to 15");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic       sel_r;
   logic [1:0] fs_r;
   logic       halt_r;
   logic       lock_r;
   logic [3:0] good_r;
   logic [7:0] err_r;
   logic       up_r;
   logic       dn_r;
   logic [2:0] flags_r;
   logic [2:0] en_r;
   logic [5:0] min_hold_r;
   logic [4:0] hour_hold_r;
   logic [5:0] alm_min_r;
   logic [4:0] alm_hour_r;
   logic [7:0] rd_data_r;
   logic       irq_r;
   logic       osc_en_r;

   // -----------------------------------------------------------------
   // Pin sampling
   // -----------------------------------------------------------------
   logic osc_rise;
   logic vco_rise;

   rtcs_sync u_osc_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pin     (i_osc_32k),
      .o_level   (),
      .o_rise    (osc_rise)
   );

   rtcs_sync u_vco_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pin     (i_vco_clk),
      .o_level   (),
      .o_rise    (vco_rise)
   );

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   wire sel_flags = i_addr == rtcs_pkg::ADDR_FLAGS;
   wire sel_en    = i_addr == rtcs_pkg::ADDR_ENABLES;
   wire sel_sec   = i_addr == rtcs_pkg::ADDR_SECONDS;
   wire sel_min   = i_addr == rtcs_pkg::ADDR_MINUTES;
   wire sel_hour  = i_addr == rtcs_pkg::ADDR_HOURS;
   wire sel_pll   = i_addr == rtcs_pkg::ADDR_PLL;
   wire sel_amin  = i_addr == rtcs_pkg::ADDR_ALM_MIN;
   wire sel_ahour = i_addr == rtcs_pkg::ADDR_ALM_HOUR;

   wire wr_flags = i_wr_stb & sel_flags;
   wire wr_en    = i_wr_stb & sel_en;
   wire wr_sec   = i_wr_stb & sel_sec;
   wire wr_min   = i_wr_stb & sel_min;
   wire wr_hour  = i_wr_stb & sel_hour;
   wire wr_pll   = i_wr_stb & sel_pll;
   wire wr_amin  = i_wr_stb & sel_amin;
   wire wr_ahour = i_wr_stb & sel_ahour;
   wire rd_sec   = i_rd_stb & sel_sec;

   // -----------------------------------------------------------------
   // Time chain
   // -----------------------------------------------------------------
   // Halt in Stop mode freezes the chain, as a dead crystal would
   wire        osc_run = ~(i_stop_mode & halt_r);
   wire        presc_wrap;
   wire        sec_wrap;
   wire        min_wrap;
   wire        hour_wrap;
   wire [5:0]  sec_count;
   wire [5:0]  min_count;
   wire [4:0]  hour_count;

   rtcs_wrap_cnt #(.W(15)) u_presc (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (osc_rise & osc_run),
      .i_load     (wr_sec),
      .i_load_val ('0),
      .i_limit    (rtcs_pkg::PRESC_LAST),
      .o_count    (),
      .o_wrap     (presc_wrap)
   );

   rtcs_wrap_cnt #(.W(6)) u_sec (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (presc_wrap),
      .i_load     (wr_sec),
      .i_load_val (i_wr_data[5:0]),
      .i_limit    (rtcs_pkg::SEC_LAST),
      .o_count    (sec_count),
      .o_wrap     (sec_wrap)
   );

   rtcs_wrap_cnt #(.W(6)) u_min (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (sec_wrap),
      .i_load     (wr_sec),
      .i_load_val (min_hold_r),
      .i_limit    (rtcs_pkg::MIN_LAST),
      .o_count    (min_count),
      .o_wrap     (min_wrap)
   );

   rtcs_wrap_cnt #(.W(5)) u_hour (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (min_wrap),
      .i_load     (wr_sec),
      .i_load_val (hour_hold_r),
      .i_limit    (rtcs_pkg::HOUR_LAST),
      .o_count    (hour_count),
      .o_wrap     (hour_wrap)
   );

   // -----------------------------------------------------------------
   // Holding and alarm registers
   // -----------------------------------------------------------------
   wire [5:0] min_hold_nxt  = wr_min  ? i_wr_data[5:0] :
                              rd_sec  ? min_count : min_hold_r;
   wire [4:0] hour_hold_nxt = wr_hour ? i_wr_data[4:0] :
                              rd_sec  ? hour_count : hour_hold_r;
   wire       alarm_match   = (alm_hour_r == hour_count) &&
                              (alm_min_r == min_count);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         min_hold_r  <= '0;
         hour_hold_r <= '0;
         alm_min_r   <= '0;
         alm_hour_r  <= '0;
      end else begin
         min_hold_r  <= min_hold_nxt;
         hour_hold_r <= hour_hold_nxt;
         alm_min_r   <= wr_amin  ? i_wr_data[5:0] : alm_min_r;
         alm_hour_r  <= wr_ahour ? i_wr_data[4:0] : alm_hour_r;
      end
   end

   // -----------------------------------------------------------------
   // Event flags and request
   // -----------------------------------------------------------------
   // Set wins over a clear in the same cycle, so no event is lost
   wire [2:0] flag_set  = {sec_wrap | presc_wrap, alarm_match, hour_wrap};
   wire [2:0] flag_clr  = wr_flags ? i_wr_data[2:0] : 3'h0;
   wire [2:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;
   wire       irq_nxt   = |(flags_r & en_r);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         flags_r <= '0;
         en_r    <= '0;
         irq_r   <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         en_r    <= wr_en ? i_wr_data[2:0] : en_r;
         irq_r   <= irq_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Clock select and oscillator control
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sel_r    <= 1'b0;
         fs_r     <= 2'h0;
         halt_r   <= 1'b0;
         osc_en_r <= 1'b1;
      end else begin
         if (wr_pll) begin
            sel_r  <= i_wr_data[rtcs_pkg::BIT_SEL];
            fs_r   <= {i_wr_data[rtcs_pkg::BIT_FS1], i_wr_data[rtcs_pkg::BIT_FS0]};
            halt_r <= i_wr_data[rtcs_pkg::BIT_HALT];
         end
         osc_en_r <= osc_run;
      end
   end

   // -----------------------------------------------------------------
   // Loop reference, divider and phase comparator
   // -----------------------------------------------------------------
   wire        ref_edge;
   wire        div_edge;
   logic [12:0] divn;

   always_comb begin
      case (fs_r)
         2'h0:    divn = rtcs_pkg::DIVN_288K;
         2'h2:    divn = rtcs_pkg::DIVN_576K;
         2'h1:    divn = rtcs_pkg::DIVN_2604K;
         default: divn = rtcs_pkg::DIVN_5208K;
      endcase
   end

   rtcs_wrap_cnt #(.W(5)) u_ref (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (osc_rise),
      .i_load     (1'b0),
      .i_load_val ('0),
      .i_limit    (rtcs_pkg::REF_LAST),
      .o_count    (),
      .o_wrap     (ref_edge)
   );

   rtcs_wrap_cnt #(.W(13)) u_divn (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_inc      (vco_rise),
      .i_load     (1'b0),
      .i_load_val ('0),
      .i_limit    (divn - 13'h1),
      .o_count    (),
      .o_wrap     (div_edge)
   );

   wire up_set   = up_r | ref_edge;
   wire dn_set   = dn_r | div_edge;
   wire pfd_done = up_set & dn_set;
   wire err_ok   = err_r <= 8'(rtcs_pkg::LOCK_TOL_CYC);
   wire [7:0] err_nxt  = ~(up_r | dn_r) ? 8'h0 :
                         (&err_r) ? err_r : err_r + 8'h1;
   wire [3:0] good_nxt = ~pfd_done ? good_r :
                         ~err_ok ? 4'h0 :
                         (good_r == 4'(LOCK_COUNT)) ? good_r : good_r + 4'h1;

   // Lock lags the divider change; software must wait before polling
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         up_r   <= 1'b0;
         dn_r   <= 1'b0;
         err_r  <= '0;
         good_r <= '0;
         lock_r <= 1'b0;
      end else begin
         up_r   <= up_set & ~pfd_done;
         dn_r   <= dn_set & ~pfd_done;
         err_r  <= pfd_done ? 8'h0 : err_nxt;
         good_r <= good_nxt;
         lock_r <= good_r == 4'(LOCK_COUNT);
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   wire [7:0] pll_rd = {sel_r, fs_r, halt_r, 3'h0, lock_r};
   wire [7:0] rd_mux = sel_flags ? {5'h0, flags_r} :
                       sel_en    ? {5'h0, en_r} :
                       sel_sec   ? {2'h0, sec_count} :
                       sel_min   ? {2'h0, min_hold_r} :
                       sel_hour  ? {3'h0, hour_hold_r} :
                       sel_pll   ? pll_rd :
                       sel_amin  ? {2'h0, alm_min_r} :
                       sel_ahour ? {3'h0, alm_hour_r} : 8'h0;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= i_rd_stb ? rd_mux : 8'h0;
      end
   end

   assign o_rd_data                 = rd_data_r;
   assign o_cpu_clock_source_select = sel_r;
   assign o_osc_enable              = osc_en_r;
   assign o_pump_up                 = up_r;
   assign o_pump_dn                 = dn_r;
   assign o_rtc_irq                 = irq_r;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_sec_write;
      wr_sec ##1 1'b1;
   endsequence

   clk_sel_reset_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
      $past(i_rst) |-> !o_cpu_clock_source_select)
      else $error("clock select not cleared by reset");

   clk_sel_write_a: assert property (wr_pll |=>
      o_cpu_clock_source_select == $past(i_wr_data[rtcs_pkg::BIT_SEL]))
      else $error("clock select does not follow write");

   osc_stop_a: assert property (i_stop_mode && halt_r |=> !o_osc_enable)
      else $error("oscillator left running in stop");

   rtc_halt_a: assert property (i_stop_mode && halt_r && !wr_sec
      |=> $stable(sec_count))
      else $error("time advanced while halted");

   sec_load_a: assert property (s_sec_write |->
      min_count == $past(min_hold_r) && hour_count == $past(hour_hold_r))
      else $error("seconds write did not load held time");

   sec_latch_a: assert property (rd_sec && !wr_min |=>
      min_hold_r == $past(min_count))
      else $error("seconds read did not latch minutes");

   alarm_flag_a: assert property (alarm_match |=> flags_r[rtcs_pkg::BIT_ALARM])
      else $error("alarm flag missing on match");

   day_flag_a: assert property (hour_wrap |=> flags_r[rtcs_pkg::BIT_DAY])
      else $error("day flag missing on rollover");

   flag_hold_a: assert property (!wr_flags |=>
      (flags_r & $past(flags_r)) == $past(flags_r))
      else $error("flag dropped without a clear");

   flag_clear_a: assert property (wr_flags && i_wr_data[0] && !hour_wrap
      |=> !flags_r[rtcs_pkg::BIT_DAY])
      else $error("day flag not cleared by write of one");

   irq_raise_a: assert property (|(flags_r & en_r) |=> o_rtc_irq)
      else $error("interrupt request missing");

   time_range_a: assert property (sec_count <= rtcs_pkg::SEC_LAST &&
      hour_count <= rtcs_pkg::HOUR_LAST)
      else $error("time counter out of range");

   lock_read_a: assert property (i_rd_stb && sel_pll |=>
      o_rd_data[rtcs_pkg::BIT_LOCK] == $past(lock_r))
      else $error("lock bit read wrong");

endmodule // rtcs_top

// ===== inc/rtcs_pkg.sv
// Constants for the real-time clock and CPU clock select block.
// Assumes an 8-bit register port on the 40 MHz system clock.
//
// How it works
// - Select bit picks CPU clock from the loop or the 32 kHz crystal.
// - Reset clears the select bit so the CPU starts on the crystal.
// - Halt bit set turns the crystal oscillator off during Stop mode.
// - Halt bit also stops the time counters during Stop mode.
// - Lock indicator reads one once the loop is stable; read only.
// - Phase comparator matches 1 kHz crystal reference to divided VCO edges.
// - Divide-by-N gives four VCO rates: 288k, 576k, 2.604M, 5.208M.
// - Seconds, minutes, hours are cascaded counters divided from 32.768 kHz.
// - Seconds write moves held hours and minutes into the counters.
// - Seconds read latches hours and minutes into the holding registers.
// - Alarm flag sets when alarm registers match the running time.
// - Flags: second tick bit 2, alarm bit 1, day rollover bit 0.
// - Enables mirror the flag positions; all cleared by reset.
// - Flags set on their event regardless of the enables.
// - Flags stay set until software clears them.
// - Writing one to a flag bit clears it; several may be pending.
// - Day event occurs when hours roll from 23 to 0.
// - Alarm needs hour and minute both equal.
// - Alarm flag keeps setting while the match holds.
// - Interrupt request is raised by any set flag with its enable.

package rtcs_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAGS    = 8'h1c;
   localparam logic [7:0] ADDR_ENABLES  = 8'h1d;
   localparam logic [7:0] ADDR_SECONDS  = 8'h20;
   localparam logic [7:0] ADDR_MINUTES  = 8'h21;
   localparam logic [7:0] ADDR_HOURS    = 8'h22;
   localparam logic [7:0] ADDR_PLL      = 8'h24;
   localparam logic [7:0] ADDR_ALM_MIN  = 8'h25;
   localparam logic [7:0] ADDR_ALM_HOUR = 8'h26;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_DAY    = 0;
   localparam int BIT_ALARM  = 1;
   localparam int BIT_SECOND = 2;
   localparam int BIT_SEL    = 7;
   localparam int BIT_FS1    = 6;
   localparam int BIT_FS0    = 5;
   localparam int BIT_HALT   = 4;
   localparam int BIT_LOCK   = 0;

   // -----------------------------------------------------------------
   // Counter limits and divide ratios
   // -----------------------------------------------------------------
   localparam logic [5:0]  SEC_LAST   = 6'h3b;
   localparam logic [5:0]  MIN_LAST   = 6'h3b;
   localparam logic [4:0]  HOUR_LAST  = 5'h17;
   localparam logic [14:0] PRESC_LAST = 15'h7fff;
   localparam logic [4:0]  REF_LAST   = 5'h1f;
   localparam logic [12:0] DIVN_288K  = 13'h0120;
   localparam logic [12:0] DIVN_576K  = 13'h0240;
   localparam logic [12:0] DIVN_2604K = 13'h0a2c;
   localparam logic [12:0] DIVN_5208K = 13'h1458;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOCK_TOL_NS   = 1000;
   localparam int LOCK_TOL_CYC  = (LOCK_TOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== hw/rtcs_sync.sv
// Two-stage synchroniser with rising-edge pulse for one pin.
// Assumes the pin toggles slower than half the system clock.
`timescale 1ns/1ps

module rtcs_sync (
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign o_level = sync_r;
   assign o_rise  = sync_r & ~prev_r;

endmodule // rtcs_sync

// ===== hw/rtcs_wrap_cnt.sv
// Wrapping counter with load; used for time, prescale and divide chains.
// Assumes the limit is stable while counting; a load beats an increment.
`timescale 1ns/1ps

module rtcs_wrap_cnt #(
   parameter int W = 6
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic         i_inc,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_load_val,
   input  wire logic [W-1:0] i_limit,
   output logic      [W-1:0] o_count,
   output logic              o_wrap
);

   logic [W-1:0] count_r;
   logic         at_end;

   if (W < 1) begin : g_bad_width
      $error("rtcs_wrap_cnt: width must be positive");
   end

   // At or past the limit also wraps, so a bad load cannot run away
   assign at_end  = count_r >= i_limit;
   assign o_wrap  = i_inc & at_end & ~i_load;
   assign o_count = count_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         count_r <= '0;
      end else if (i_load) begin
         count_r <= i_load_val;
      end else if (i_inc) begin
         count_r <= at_end ? '0 : count_r + 1'b1;
      end
   end

endmodule // rtcs_wrap_cnt

// ===== testbench/rtcs_top_tb_top.sv
// Self-checking bench for the real-time clock and clock select block.
// Assumes the register port of rtcs_top and a bench-made crystal pin.
`timescale 1ns/1ps

module rtcs_top_tb_top;

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic       i_sys_clk;
   logic       i_rst;
   logic [7:0] i_addr;
   logic [7:0] i_wr_data;
   logic       i_wr_stb;
   logic       i_rd_stb;
   logic [7:0] o_rd_data;
   logic       i_osc_32k;
   logic       i_vco_clk;
   logic       i_stop_mode;
   logic       o_cpu_clock_source_select;
   logic       o_osc_enable;
   logic       o_pump_up;
   logic       o_pump_dn;
   logic       o_rtc_irq;
   logic       xtal_run;
   logic [1:0] xtal_phase;
   logic [7:0] rd_val;
   int         n_errors;
   int         checks_done;
   int         wait_cyc;

   rtcs_top #(.LOCK_COUNT(2)) dut (
      .i_sys_clk                 (i_sys_clk),
      .i_rst                     (i_rst),
      .i_addr                    (i_addr),
      .i_wr_data                 (i_wr_data),
      .i_wr_stb                  (i_wr_stb),
      .i_rd_stb                  (i_rd_stb),
      .o_rd_data                 (o_rd_data),
      .i_osc_32k                 (i_osc_32k),
      .i_vco_clk                 (i_vco_clk),
      .i_stop_mode               (i_stop_mode),
      .o_cpu_clock_source_select (o_cpu_clock_source_select),
      .o_osc_enable              (o_osc_enable),
      .o_pump_up                 (o_pump_up),
      .o_pump_dn                 (o_pump_dn),
      .o_rtc_irq                 (o_rtc_irq)
   );

   // ----------------------------------------------------------------
   // Clock and crystal
   // ----------------------------------------------------------------
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   // One high cycle in three keeps a full second under the cycle budget
   always @(posedge i_sys_clk) begin
      xtal_phase <= (xtal_phase == 2'h2) ? 2'h0 : xtal_phase + 2'h1;
      i_osc_32k  <= xtal_run && (xtal_phase == 2'h0);
   end

   // ----------------------------------------------------------------
   // Bus tasks, compare and verdict
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_stb  <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_stb  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_addr   <= a;
      i_rd_stb <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_stb <= 1'b0;
      #1;
      rd_val = o_rd_data;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(rd_val, exp);
   endtask

   task automatic report_and_stop;
      $display("Mismatches: %0d  comparisons: %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Bound covers one crystal second plus register traffic
   initial begin
      #(100000 * 25);
      n_errors++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      i_rst = 1'b1; i_addr = 8'h00; i_wr_data = 8'h00; i_wr_stb = 1'b0;
      i_rd_stb = 1'b0; i_osc_32k = 1'b0; i_vco_clk = 1'b0; i_stop_mode = 1'b0;
      xtal_run = 1'b0; xtal_phase = 2'h0; n_errors = 0; checks_done = 0;
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      #1;
      chk({7'h0, o_cpu_clock_source_select}, 8'h00);
      chk({7'h0, o_osc_enable}, 8'h01);
      // Time and alarm are both 00:00 out of reset, so the alarm flag rises at once
      rdchk(rtcs_pkg::ADDR_FLAGS, 8'h02);
      rdchk(rtcs_pkg::ADDR_ENABLES, 8'h00);
      rdchk(rtcs_pkg::ADDR_PLL, 8'h00);
      // Unmapped place reads zero and ignores writes
      wr(8'h00, 8'hff);
      rdchk(8'h00, 8'h00);
      // Lock bit cannot be written; loop clock selected
      wr(rtcs_pkg::ADDR_PLL, 8'hff);
      repeat (4) @(posedge i_sys_clk);
      rdchk(rtcs_pkg::ADDR_PLL, 8'hf0);
      chk({7'h0, o_cpu_clock_source_select}, 8'h01);
      @(posedge i_sys_clk);
      i_stop_mode <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk({7'h0, o_osc_enable}, 8'h00);
      wr(rtcs_pkg::ADDR_PLL, 8'h80);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk({7'h0, o_osc_enable}, 8'h01);
      @(posedge i_sys_clk);
      i_stop_mode <= 1'b0;
      wr(rtcs_pkg::ADDR_PLL, 8'h00);
      #1;
      chk({7'h0, o_cpu_clock_source_select}, 8'h00);
      wr(rtcs_pkg::ADDR_ENABLES, 8'hff);
      rdchk(rtcs_pkg::ADDR_ENABLES, 8'h07);
      chk({7'h0, o_rtc_irq}, 8'h01);
      // Time set through the holding registers: 23:59:59
      wr(rtcs_pkg::ADDR_MINUTES, 8'h3b);
      wr(rtcs_pkg::ADDR_HOURS, 8'h17);
      wr(rtcs_pkg::ADDR_SECONDS, 8'h3b);
      wr(rtcs_pkg::ADDR_MINUTES, 8'h05);
      rdchk(rtcs_pkg::ADDR_SECONDS, 8'h3b);
      rdchk(rtcs_pkg::ADDR_MINUTES, 8'h3b);
      rdchk(rtcs_pkg::ADDR_HOURS, 8'h17);
      wr(rtcs_pkg::ADDR_ALM_MIN, 8'h00);
      wr(rtcs_pkg::ADDR_ALM_HOUR, 8'h00);
      rdchk(rtcs_pkg::ADDR_ALM_MIN, 8'h00);
      // Alarm enable kept off to show flags set regardless
      wr(rtcs_pkg::ADDR_ENABLES, 8'h05);
      wr(rtcs_pkg::ADDR_FLAGS, 8'h07);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk({7'h0, o_rtc_irq}, 8'h00);
      xtal_run <= 1'b1;
      wait_cyc = 0;
      while (o_rtc_irq !== 1'b1 && wait_cyc < 99000) begin
         @(posedge i_sys_clk);
         wait_cyc++;
      end
      xtal_run <= 1'b0;
      chk({7'h0, o_rtc_irq}, 8'h01);
      chk({6'h0, o_pump_up, o_pump_dn}, 8'h02);
      rdchk(rtcs_pkg::ADDR_FLAGS, 8'h07);
      rdchk(rtcs_pkg::ADDR_SECONDS, 8'h00);
      rdchk(rtcs_pkg::ADDR_MINUTES, 8'h00);
      rdchk(rtcs_pkg::ADDR_HOURS, 8'h00);
      // Alarm flag comes back while the match still holds
      wr(rtcs_pkg::ADDR_FLAGS, 8'h07);
      rdchk(rtcs_pkg::ADDR_FLAGS, 8'h02);
      #1;
      chk({7'h0, o_rtc_irq}, 8'h00);
      wr(rtcs_pkg::ADDR_ENABLES, 8'h02);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk({7'h0, o_rtc_irq}, 8'h01);
      // Moving the alarm ends the match so the clear sticks
      wr(rtcs_pkg::ADDR_ALM_MIN, 8'h01);
      rdchk(rtcs_pkg::ADDR_FLAGS, 8'h02);
      wr(rtcs_pkg::ADDR_FLAGS, 8'h02);
      rdchk(rtcs_pkg::ADDR_FLAGS, 8'h00);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk({7'h0, o_rtc_irq}, 8'h00);
      report_and_stop();
   end

endmodule // rtcs_top_tb_top
